//--- src/smas_defs.vh
/*
 * constants for the static memory access sequencer: field encodings,
 * reset values and timing counts.
 * assumes inclusion by bare name from the design file only.
 */
`ifndef SMAS_DEFS_VH
`define SMAS_DEFS_VH

// ****************************************************************
// field encodings
// ****************************************************************
`define SMAS_BW_8BIT      2'h2
`define SMAS_BW_16BIT     2'h1
`define SMAS_BAT_BYTEWR   1'h0
`define SMAS_BAT_BYTESEL  1'h1
`define SMAS_DRP_STD      1'h0
`define SMAS_DRP_EARLY    1'h1

// ****************************************************************
// sizes and timing
// ****************************************************************
`define SMAS_ADDR_W       23
`define SMAS_NUM_CS       8
`define SMAS_SYNC_STAGES  2
`define SMAS_TDF_MAX      4'hF
`define SMAS_CS_IDLE      8'hFF

`endif

//--- src/smas_static_memory_ctrl.v
/*
 * static memory access sequencer: turns single internal requests into
 * chip select, address, strobe and data sequences for eight external
 * static devices on an 8/16-bit bus.
 * assumes a requester on clk_i that holds req until ack, and a
 * half-cycle phase shaper outside that builds low-phase strobes from
 * the *_half_o qualifiers with the inverted clock.
 */
// How it works
// - drive 23-bit address, A0 meaningful for 8-bit
// - eight active-low chip selects, 8 Mbyte each
// - per-select width: 10 is 8-bit, 01 16-bit
// - write type: 0 byte-write, 1 byte-select
// - byte-write: two write strobes, one read strobe
// - byte-select: byte selects, one write strobe
// - write data held half period past strobe
// - write strobe low in second clock half
// - per-select read protocol, standard after reset
// - standard read: strobe in second half only
// - early read: strobe from cycle start, continuous
// - wait enable inserts programmed wait count cycles
// - write low for the last half cycle only, after all waits
// - external wait low freezes outputs and counters
// - external wait passes two-flop synchroniser
// - core clock stopped while external wait holds
// - float cycles after read before write/other select
// - float time elapses during internal accesses
// - no float for internal or same-select reads
// - early read: extra wait after write then read
// - one wait between different selects unless inserted
`timescale 1ns/1ps
`include "smas_defs.vh"

module smas_static_memory_ctrl #(
	parameter NUM_CS = `SMAS_NUM_CS,
	parameter AW     = `SMAS_ADDR_W
) (
	// clock and reset
	input  wire              clk_i,
	input  wire              rst_b_i,
	// per-select configuration, select k in bits of slot k
	input  wire [2*NUM_CS-1:0] bus_width_field_i,
	input  wire [NUM_CS-1:0]   write_access_type_field_i,
	input  wire [NUM_CS-1:0]   read_protocol_field_i,
	input  wire [NUM_CS-1:0]   wait_enable_field_i,
	input  wire [7*NUM_CS-1:0] wait_count_field_i,
	input  wire [4*NUM_CS-1:0] data_float_cycles_field_i,
	// internal request port
	input  wire              req_i,
	input  wire              req_ext_i,
	input  wire              req_wr_i,
	input  wire [2:0]        req_cs_i,
	input  wire [AW-1:0]     req_addr_i,
	input  wire [1:0]        req_be_i,
	input  wire [15:0]       req_wdata_i,
	output wire              ack_o,
	output reg  [15:0]       rdata_o,
	output wire              core_clk_stop_o,
	// external pins
	output reg  [NUM_CS-1:0] chip_select_n_lines_o,
	output reg  [AW-1:1]     addr_hi_o,
	output reg               addr0_lower_byte_select_n_o,
	output reg               read_strobe_n_o,
	output reg               read_half_o,
	output reg               write_half_o,
	output reg               lower_write_strobe_en_o,
	output reg               upper_write_strobe_en_o,
	output reg               upper_byte_select_n_o,
	output reg  [15:0]       data_o,
	output reg               data_oe_o,
	input  wire [15:0]       data_i,
	input  wire              ext_wait_n_i
);

	// ****************************************************************
	// states
	// ****************************************************************
	localparam ST_IDLE  = 2'h0;	// waiting for request
	localparam ST_GAP   = 2'h1;	// float / select change / early-read gap
	localparam ST_PULSE = 2'h2;	// strobe cycles
	localparam ST_HOLD  = 2'h3;	// write data hold half period

	reg  [1:0]        state_reg;	// sequencer state
	reg  [6:0]        cnt_reg;	// wait / gap counter
	reg  [3:0]        float_reg;	// pending float cycles
	reg  [2:0]        last_cs_reg;	// select of last external access
	reg               last_rd_reg;	// last external access was a read
	reg               last_valid_reg;	// any external access done yet
	reg               ack_reg;	// one-cycle completion
	reg               sync1_reg;	// synchroniser first stage
	reg               sync2_reg;	// synchronised wait, low = hold
	reg               cur_wr_reg;	// current access is a write
	reg  [2:0]        cur_cs_reg;	// current select

	// ****************************************************************
	// per-select field pick-up
	// ****************************************************************
	wire [1:0] bw   = bus_width_field_i[2*req_cs_i +: 2];
	wire       write_access_type_field  = write_access_type_field_i[req_cs_i];
	wire       read_protocol_field  = read_protocol_field_i[req_cs_i];
	wire       wait_enable_field = wait_enable_field_i[req_cs_i];
	wire [6:0] wait_count_field  = wait_count_field_i[7*req_cs_i +: 7];
	wire [3:0] tdf_cur = data_float_cycles_field_i[4*last_cs_reg +: 4];
	wire       wide = (bw == `SMAS_BW_16BIT);
	wire       hold_n = sync2_reg;

	assign ack_o = ack_reg;
	assign core_clk_stop_o = (state_reg == ST_PULSE) & ~hold_n;

	// gap needed before new external access
	wire diff_cs   = last_valid_reg & (last_cs_reg != req_cs_i);
	wire need_flt  = last_rd_reg & (req_wr_i | diff_cs);
	wire [3:0] flt = need_flt ? float_reg : 4'h0;
	wire er_wait   = (read_protocol_field == `SMAS_DRP_EARLY) & last_valid_reg & ~last_rd_reg & ~req_wr_i;
	wire cs_wait   = diff_cs & (flt == 4'h0) & ~er_wait;
	wire [6:0] gap = {3'h0, flt} + {6'h0, er_wait} + {6'h0, cs_wait};

	// ****************************************************************
	// synchroniser for the external wait
	// ****************************************************************
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end
		else
		begin
			sync1_reg <= ext_wait_n_i;
			sync2_reg <= sync1_reg;
		end
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 7'h00;
			float_reg <= 4'h0;
			last_cs_reg <= 3'h0;
			last_rd_reg <= 1'b0;
			last_valid_reg <= 1'b0;
			ack_reg <= 1'b0;
			cur_wr_reg <= 1'b0;
			cur_cs_reg <= 3'h0;
			rdata_o <= 16'h0000;
			chip_select_n_lines_o <= `SMAS_CS_IDLE;
			addr_hi_o <= {(AW-1){1'b0}};
			addr0_lower_byte_select_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1;
			read_half_o <= 1'b0;
			write_half_o <= 1'b0;
			lower_write_strobe_en_o <= 1'b0;
			upper_write_strobe_en_o <= 1'b0;
			upper_byte_select_n_o <= 1'b1;
			data_o <= 16'h0000;
			data_oe_o <= 1'b0;
		end
		else
		begin
			ack_reg <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					// float time runs down while idle or internal
					if (float_reg != 4'h0)
						float_reg <= float_reg - 4'h1;
					if (!read_half_o)
						read_strobe_n_o <= 1'b1;
					if (req_i && !ack_reg && !req_ext_i)
						ack_reg <= 1'b1;
					else if (req_i && !ack_reg)
					begin
						// latch select and address for the access
						cur_wr_reg <= req_wr_i;
						cur_cs_reg <= req_cs_i;
						addr_hi_o <= req_addr_i[AW-1:1];
						if (!wide || req_wr_i || read_protocol_field == `SMAS_DRP_EARLY)
							read_strobe_n_o <= 1'b1;
						data_o <= req_wdata_i;
						if (gap != 7'h00)
						begin
							cnt_reg <= gap - 7'h01;
							state_reg <= ST_GAP;
							chip_select_n_lines_o <= `SMAS_CS_IDLE;
						end
						else
						begin
							cnt_reg <= wait_enable_field ? wait_count_field : 7'h00;
							state_reg <= ST_PULSE;
							chip_select_n_lines_o <= ~(8'h01 << req_cs_i);
							data_oe_o <= req_wr_i;
							write_half_o <= req_wr_i & ~(wait_enable_field & wait_count_field != 7'h00);
							read_half_o <= ~req_wr_i & (read_protocol_field == `SMAS_DRP_STD);
							read_strobe_n_o <= req_wr_i | (read_protocol_field == `SMAS_DRP_STD);
						end
						// bytes: 8-bit uses A0, 16-bit uses selects or strobes
						if (!wide)
						begin
							addr0_lower_byte_select_n_o <= req_addr_i[0];
							upper_byte_select_n_o <= 1'b1;
							lower_write_strobe_en_o <= req_wr_i;
							upper_write_strobe_en_o <= 1'b0;
						end
						else if (write_access_type_field == `SMAS_BAT_BYTESEL)
						begin
							addr0_lower_byte_select_n_o <= ~req_be_i[0];
							upper_byte_select_n_o <= ~req_be_i[1];
							lower_write_strobe_en_o <= req_wr_i;
							upper_write_strobe_en_o <= 1'b0;
						end
						else
						begin
							addr0_lower_byte_select_n_o <= 1'b1;
							upper_byte_select_n_o <= 1'b1;
							lower_write_strobe_en_o <= req_wr_i & req_be_i[0];
							upper_write_strobe_en_o <= req_wr_i & req_be_i[1];
						end
					end
				end
				ST_GAP:
				begin
					// inserted wait cycle, nothing driven
					if (cnt_reg == 7'h00)
					begin
						float_reg <= 4'h0;
						cnt_reg <= wait_enable_field ? wait_count_field : 7'h00;
						state_reg <= ST_PULSE;
						chip_select_n_lines_o <= ~(8'h01 << cur_cs_reg);
						data_oe_o <= cur_wr_reg;
						write_half_o <= cur_wr_reg & ~(wait_enable_field & wait_count_field != 7'h00);
						read_half_o <= ~cur_wr_reg & (read_protocol_field == `SMAS_DRP_STD);
						read_strobe_n_o <= cur_wr_reg | (read_protocol_field == `SMAS_DRP_STD);
					end
					else
						cnt_reg <= cnt_reg - 7'h01;
				end
				ST_PULSE:
				begin
					// freeze everything while the device holds wait
					if (hold_n)
					begin
						if (cnt_reg == 7'h01)
							write_half_o <= cur_wr_reg;
						if (cnt_reg != 7'h00)
							cnt_reg <= cnt_reg - 7'h01;
						else
						begin
							if (!cur_wr_reg)
								rdata_o <= data_i;
							ack_reg <= 1'b1;
							write_half_o <= 1'b0;
							read_half_o <= 1'b0;
							lower_write_strobe_en_o <= 1'b0;
							upper_write_strobe_en_o <= 1'b0;
							last_cs_reg <= cur_cs_reg;
							last_rd_reg <= ~cur_wr_reg;
							last_valid_reg <= 1'b1;
							float_reg <= cur_wr_reg ? 4'h0 :
								data_float_cycles_field_i[4*cur_cs_reg +: 4];
							state_reg <= cur_wr_reg ? ST_HOLD : ST_IDLE;
							if (!cur_wr_reg)
								chip_select_n_lines_o <= `SMAS_CS_IDLE;
						end
					end
				end
				default:
				begin
					// data stays half period beyond strobe rise
					data_oe_o <= 1'b0;
					chip_select_n_lines_o <= `SMAS_CS_IDLE;
					state_reg <= ST_IDLE;
				end
			endcase
			if (tdf_cur > `SMAS_TDF_MAX)
				float_reg <= `SMAS_TDF_MAX;
		end
	end

endmodule // smas_static_memory_ctrl

//--- verif/smas_checker_sva.sv
/* pin checker for the access sequencer.
   assumes a bind onto smas_static_memory_ctrl, one clock. */
`timescale 1ns/1ps
module smas_checker #(
	parameter NUM_CS = 8,
	parameter AW     = 23
) (
	// watched ports
	input wire              clk_i,
	input wire              rst_b_i,
	input wire              ext_wait_n_i,
	input wire              ack_o,
	input wire              core_clk_stop_o,
	input wire [NUM_CS-1:0] chip_select_n_lines_o,
	input wire [AW-1:1]     addr_hi_o,
	input wire              read_half_o,
	input wire              write_half_o,
	input wire [15:0]       data_o,
	input wire              data_oe_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// end of a write strobe phase
	sequence s_wr_end;
		write_half_o ##1 !write_half_o;
	endsequence
	// two successive cycles inside one external access
	sequence s_cs_start;
		!(&chip_select_n_lines_o) ##1 !(&chip_select_n_lines_o);
	endsequence
	a_one_select: assert property ($countones(~chip_select_n_lines_o) <= 1)
		else $error("two selects low");
	a_strobe_selected: assert property ((read_half_o || write_half_o) |->
		!(&chip_select_n_lines_o)) else $error("strobe without select");
	a_read_undriven: assert property (read_half_o |-> !data_oe_o && !write_half_o)
		else $error("bus driven in read");
	a_data_hold: assert property (s_wr_end |-> data_oe_o && $stable(data_o))
		else $error("write data not held");
	a_select_steady: assert property (s_cs_start |-> $stable(addr_hi_o) &&
		$stable(chip_select_n_lines_o)) else $error("select or address moved");
	a_stop_freeze: assert property (core_clk_stop_o |=> !ack_o &&
		$stable(chip_select_n_lines_o) && $stable(addr_hi_o)) else $error("no freeze");
	a_wait_synced: assert property (core_clk_stop_o |-> !$past(ext_wait_n_i, 2))
		else $error("wait used unsynchronised");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than a cycle");
endmodule // smas_checker

bind smas_static_memory_ctrl smas_checker #(.NUM_CS(NUM_CS), .AW(AW)) u_chk (.clk_i(clk_i),
	.rst_b_i(rst_b_i), .ext_wait_n_i(ext_wait_n_i), .ack_o(ack_o),
	.core_clk_stop_o(core_clk_stop_o), .chip_select_n_lines_o(chip_select_n_lines_o),
	.addr_hi_o(addr_hi_o), .read_half_o(read_half_o), .write_half_o(write_half_o),
	.data_o(data_o), .data_oe_o(data_oe_o));

//--- verif/smas_mem_model.sv
/* far-side static memory: 16 half-words, byte strobes, wait pin.
   assumes 16-bit byte-write selects and a stall count from the bench. */
`timescale 1ns/1ps
module smas_mem_model (
	// pins seen from the memory
	input  wire        clk_i,
	input  wire [7:0]  cs_n_i,
	input  wire [22:1] addr_i,
	input  wire        rd_n_i,
	input  wire        rd_half_i,
	input  wire        wr_half_i,
	input  wire        lo_en_i,
	input  wire        hi_en_i,
	input  wire [15:0] wdata_i,
	input  wire [3:0]  stall_i,
	output wire [15:0] rdata_o,
	output wire        wait_n_o
);
	reg  [15:0] mem [0:15];
	reg  [15:0] last_reg = 16'h0;
	reg  [3:0]  cnt_reg = 4'h0;
	reg         sel_reg = 1'h0;
	wire        sel = !(&cs_n_i);
	wire        rd = sel && (rd_half_i || !rd_n_i);
	wire [3:0]  ix = addr_i[4:1];
	// a released bus shows the inverse of its last value
	assign rdata_o = rd ? mem[ix] : ~last_reg;
	// wait low from the second access cycle, one clock after select falls, released long before hold
	assign wait_n_o = (cnt_reg == 4'h0);
	always @(posedge clk_i)
	begin
		last_reg <= rdata_o;
		sel_reg <= sel;
		if (sel && !sel_reg)
			cnt_reg <= stall_i;
		else if (cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
		if (wr_half_i && lo_en_i)
			mem[ix][7:0] <= wdata_i[7:0];
		if (wr_half_i && hi_en_i)
			mem[ix][15:8] <= wdata_i[15:8];
	end
endmodule // smas_mem_model

//--- verif/tb_smas_static_memory_ctrl.sv
/* testbench for the access sequencer: request tasks and checks.
   assumes the memory model on the far side. */
`timescale 1ns/1ps
module tb_smas_static_memory_ctrl;
	reg         clk_i = 1'h0, rst_b_i = 1'h0;
	reg         req_i = 1'h0, req_ext_i = 1'h0, req_wr_i = 1'h0;
	reg  [2:0]  req_cs_i = 3'h0;
	reg  [22:0] req_addr_i = 23'h0;
	reg  [1:0]  req_be_i = 2'h3;
	reg  [15:0] req_wdata_i = 16'h0, rdat;
	reg  [7:0]  read_protocol_field_i = 8'h04;
	reg  [3:0]  stall = 4'h0;
	wire        ack_o, read_strobe_n_o, read_half_o, write_half_o, ext_wait_n_i;
	wire        lower_write_strobe_en_o, upper_write_strobe_en_o;
	wire [15:0] rdata_o, data_o, data_i;
	wire [7:0]  chip_select_n_lines_o;
	wire [22:1] addr_hi_o;
	int         fail_count = 0, comparisons = 0, lat, k;
	always #10 clk_i = ~clk_i;
	smas_static_memory_ctrl dut (.clk_i, .rst_b_i, .bus_width_field_i(16'h5555),
		.write_access_type_field_i(8'h00), .read_protocol_field_i,
		.wait_enable_field_i(8'h02), .wait_count_field_i(56'h180),
		.data_float_cycles_field_i(32'h50), .req_i, .req_ext_i, .req_wr_i, .req_cs_i,
		.req_addr_i, .req_be_i, .req_wdata_i, .ack_o, .rdata_o, .core_clk_stop_o(),
		.chip_select_n_lines_o, .addr_hi_o, .addr0_lower_byte_select_n_o(),
		.read_strobe_n_o, .read_half_o, .write_half_o, .lower_write_strobe_en_o,
		.upper_write_strobe_en_o, .upper_byte_select_n_o(), .data_o, .data_oe_o(),
		.data_i, .ext_wait_n_i);
	smas_mem_model mem (.clk_i, .cs_n_i(chip_select_n_lines_o), .addr_i(addr_hi_o),
		.rd_n_i(read_strobe_n_o), .rd_half_i(read_half_o), .wr_half_i(write_half_o),
		.lo_en_i(lower_write_strobe_en_o), .hi_en_i(upper_write_strobe_en_o),
		.wdata_i(data_o), .stall_i(stall), .rdata_o(data_i), .wait_n_o(ext_wait_n_i));
	// compare and count
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one request held until ack; lat counts edges from taking to ack
	task acc(input logic e, input logic w, input logic [2:0] c, input logic [22:0] a,
		input logic [15:0] d);
		@(negedge clk_i);
		{req_ext_i, req_wr_i, req_cs_i, req_addr_i, req_wdata_i} = {e, w, c, a, d};
		req_i = 1'h1;
		lat = 0;
		do
			@(posedge clk_i) #1 lat++;
		while (ack_o !== 1'h1 && lat < 300);
		if (ack_o !== 1'h1)
		begin
			fail_count++;
			$display("FAIL t=%0t ack %h exp %h", $time, ack_o, 1'h1);
		end
		rdat = rdata_o;
		@(negedge clk_i);
		req_i = 1'h0;
	endtask
	task print_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog
	initial
	begin
		repeat (5000) @(posedge clk_i);
		fail_count++;
		print_verdict;
	end
	initial
	begin
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		rst_b_i = 1'h1;
		acc(1, 1, 0, 23'h2, 16'hA55A);
		acc(1, 1, 0, 23'h4, 16'h1234);
		chk(lat[15:0], 16'h0002);
		acc(1, 0, 0, 23'h2, 16'h0);
		chk(rdat, 16'hA55A);
		acc(1, 1, 1, 23'h6, 16'hBEEF);
		chk(lat[15:0], 16'h0006);
		acc(1, 0, 1, 23'h6, 16'h0);
		chk(lat[15:0], 16'h0005);
		acc(1, 0, 1, 23'h6, 16'h0);
		chk(lat[15:0], 16'h0005);
		chk(rdat, 16'hBEEF);
		acc(1, 1, 1, 23'h8, 16'h0F0F);
		chk({15'h0, lat > 5}, 16'h0001);
		acc(1, 0, 1, 23'h8, 16'h0);
		for (k = 0; k < 16; k++)
		begin
			acc(0, 0, 1, 23'h8, 16'h0);
			chk(lat[15:0], 16'h0001);
		end
		acc(1, 1, 1, 23'h8, 16'h7E7E);
		chk(lat[15:0], 16'h0005);
		req_be_i = 2'h1;
		acc(1, 1, 1, 23'h8, 16'hFFFF);
		req_be_i = 2'h3;
		acc(1, 0, 1, 23'h8, 16'h0);
		chk(rdat, 16'h7EFF);
		acc(1, 1, 2, 23'hA, 16'hC3C3);
		acc(1, 0, 2, 23'hA, 16'h0);
		chk(lat[15:0], 16'h0003);
		chk(rdat, 16'hC3C3);
		read_protocol_field_i = 8'h00;
		acc(1, 1, 2, 23'hA, 16'h3C3C);
		acc(1, 0, 2, 23'hA, 16'h0);
		chk(lat[15:0], 16'h0002);
		stall = 4'h4;
		acc(1, 1, 1, 23'hC, 16'h5A5A);
		stall = 4'h0;
		chk({15'h0, lat > 6}, 16'h0001);
		acc(1, 0, 1, 23'hC, 16'h0);
		chk(rdat, 16'h5A5A);
		print_verdict;
	end
endmodule // tb_smas_static_memory_ctrl
